// ### pmx_port_ctrl.sv
// port pin mode, pull-up and crossbar control with an avalon-mm slave
`timescale 1ns/10ps
module pmx_port_ctrl (
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	// avalon-mm slave
	input  wire logic [7:0]  AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	input  wire logic [3:0]  AVS_BYTEENABLE_I,
	output logic      [31:0] AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O,
	// pads of the four port groups
	input  wire logic [31:0] PAD_IN_I,
	output logic      [31:0] PAD_OUT_O,
	output logic      [31:0] PAD_OE_O,
	output logic      [31:0] PAD_PULLUP_O,
	// peripheral side of the crossbar
	input  wire logic [11:0] PERIPH_OUT_I,
	input  wire logic [11:0] PERIPH_OE_I,
	output logic      [11:0] PERIPH_IN_O,
	// external memory interface takeover
	input  wire logic        EXT_MEM_ACTIVE_I,
	input  wire logic        EXT_MEM_READ_I,
	input  wire logic [31:0] EXT_MEM_PIN_USE_I,
	input  wire logic [31:0] EXT_MEM_PIN_VAL_I,
	input  wire logic [31:0] EXT_MEM_DATA_BUS_I
);

	// stored registers
	logic [31:0] data_q;
	logic [31:0] data_d;
	logic [31:0] out_mode_q;
	logic [31:0] out_mode_d;
	logic [31:0] in_mode_q;
	logic [31:0] in_mode_d;
	logic [31:0] cfg_q;
	logic [31:0] cfg_d;

	// bus handshake state
	logic        ack_q;
	logic        ack_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// pad and peripheral outputs
	logic [31:0] pad_out_q;
	logic [31:0] pad_out_d;
	logic [31:0] pad_oe_q;
	logic [31:0] pad_oe_d;
	logic [31:0] pad_pu_q;
	logic [31:0] pad_pu_d;
	logic [11:0] periph_in_q;
	logic [11:0] periph_in_d;

	// crossbar signals
	logic [11:0]      fn_en;
	logic [31:0]      skip;
	logic [31:0]      alloc;
	logic [31:0][3:0] fn_sel;
	logic [31:0]      analog;
	logic [31:0]      pin_level;

	// request and write qualifiers
	logic        req;
	logic        wr_go;
	logic        xbar_en;
	logic        ext_mem_low;

	assign req      = AVS_READ_I | AVS_WRITE_I;
	assign wr_go    = AVS_WRITE_I & ack_q;
	assign xbar_en  = cfg_q[pmx_pkg::CFG_XBAR_EN];
	assign ext_mem_low = cfg_q[pmx_pkg::CFG_EXT_MEM_LOW];

	// one wait cycle per access: waitrequest drops in the second cycle
	assign AVS_WAITREQUEST_O = req & ~ack_q;
	assign AVS_READDATA_O    = rdata_q;
	assign PAD_OUT_O         = pad_out_q;
	assign PAD_OE_O          = pad_oe_q;
	assign PAD_PULLUP_O      = pad_pu_q;
	assign PERIPH_IN_O       = periph_in_q;

	// group 0 has no input-mode bits, so it is always digital
	assign analog    = ~(in_mode_q | ~pmx_pkg::IN_MODE_MASK);
	// analog pins read as zero and feed no digital logic
	assign pin_level = PAD_IN_I & ~analog;

	// function requests from the enable bits of the config register
	always_comb begin
		fn_en = '0;
		fn_en[pmx_pkg::FN_TX0]  = cfg_q[pmx_pkg::CFG_EN_SER0];
		fn_en[pmx_pkg::FN_SERIAL0_RECEIVE] = cfg_q[pmx_pkg::CFG_EN_SER0];
		fn_en[pmx_pkg::FN_SCK]  = cfg_q[pmx_pkg::CFG_EN_SPI];
		fn_en[pmx_pkg::FN_MISO] = cfg_q[pmx_pkg::CFG_EN_SPI];
		fn_en[pmx_pkg::FN_MOSI] = cfg_q[pmx_pkg::CFG_EN_SPI];
		// three-wire spi leaves the select line without a pin
		fn_en[pmx_pkg::FN_SSEL] = cfg_q[pmx_pkg::CFG_EN_SPI]
			& ~cfg_q[pmx_pkg::CFG_SPI_3WIRE];
		fn_en[pmx_pkg::FN_SDA]  = cfg_q[pmx_pkg::CFG_EN_SMB];
		fn_en[pmx_pkg::FN_SCL]  = cfg_q[pmx_pkg::CFG_EN_SMB];
		fn_en[pmx_pkg::FN_TX1]  = cfg_q[pmx_pkg::CFG_EN_SER1];
		fn_en[pmx_pkg::FN_SERIAL1_RECEIVE] = cfg_q[pmx_pkg::CFG_EN_SER1];
		fn_en[pmx_pkg::FN_INT0] = cfg_q[pmx_pkg::CFG_EN_INT0];
		fn_en[pmx_pkg::FN_INT1] = cfg_q[pmx_pkg::CFG_EN_INT1];
	end

	// pins the allocator passes over
	always_comb begin
		skip = analog & ~pmx_pkg::ANALOG_KEEP;
		if (ext_mem_low) begin
			skip[pmx_pkg::PIN_WR] = 1'b1;
			skip[pmx_pkg::PIN_RD] = 1'b1;
			if (cfg_q[pmx_pkg::CFG_EXT_MEM_MUX]) begin
				skip[pmx_pkg::PIN_ALE] = 1'b1;
			end
		end
	end

	// priority allocation of pins to functions
	pmx_xbar_alloc u_alloc (
		.fn_en_i  (fn_en),
		.skip_i   (skip),
		.alloc_o  (alloc),
		.fn_sel_o (fn_sel)
	);

	// per-pin drive, pull-up and peripheral input routing
	always_comb begin
		logic       val;
		logic       drive;
		logic       od;
		logic [3:0] f;
		val         = 1'b0;
		drive       = 1'b0;
		od          = 1'b0;
		f           = '0;
		pad_out_d   = '0;
		pad_oe_d    = '0;
		pad_pu_d    = '0;
		periph_in_d = '0;
		for (int p = 0; p < pmx_pkg::NUM_PINS; p++) begin
			f = fn_sel[p];
			// output-mode bit picks the style for gpio and peripheral pins
			od = ~out_mode_q[p];
			if (alloc[p]) begin
				// peripheral owns the pin; the data bit has no say
				val   = PERIPH_OUT_I[f];
				drive = PERIPH_OE_I[f] & ~pmx_pkg::FN_INPUT_MASK[f];
				periph_in_d[f] = pin_level[p];
				// smbus lines and mode-0 receive lines never drive high
				if ((f == 4'(pmx_pkg::FN_SDA)) || (f == 4'(pmx_pkg::FN_SCL))
					|| ((f == 4'(pmx_pkg::FN_SERIAL0_RECEIVE))
					&& cfg_q[pmx_pkg::CFG_SER0_MODE0])
					|| ((f == 4'(pmx_pkg::FN_SERIAL1_RECEIVE))
					&& cfg_q[pmx_pkg::CFG_SER1_MODE0])) begin
					od = 1'b1;
				end
			end else begin
				val   = data_q[p];
				drive = 1'b1;
			end
			// an off-chip move overrides levels but not the drive style
			if (EXT_MEM_ACTIVE_I && ext_mem_low && EXT_MEM_PIN_USE_I[p]) begin
				val   = EXT_MEM_PIN_VAL_I[p];
				drive = ~(EXT_MEM_READ_I & EXT_MEM_DATA_BUS_I[p]);
			end
			// open-drain only sinks; a one lets the line float
			if (od) begin
				pad_out_d[p] = 1'b0;
				pad_oe_d[p]  = drive & ~val;
			end else begin
				pad_out_d[p] = val;
				pad_oe_d[p]  = drive;
			end
			// no pin may drive before the crossbar is switched on
			if (!xbar_en) begin
				pad_oe_d[p] = 1'b0;
			end
			// pull-up yields to a driven low, analog mode and global off
			pad_pu_d[p] = ~cfg_q[pmx_pkg::CFG_PU_DIS]
				& ~(pad_oe_d[p] & ~pad_out_d[p])
				& ~analog[p];
		end
	end

	// register writes take effect on the edge where waitrequest is low
	always_comb begin
		data_d     = data_q;
		out_mode_d = out_mode_q;
		in_mode_d  = in_mode_q;
		cfg_d      = cfg_q;
		if (wr_go) begin
			unique case (AVS_ADDRESS_I)
				pmx_pkg::OFF_DATA, pmx_pkg::OFF_LATCH: begin
					data_d = pmx_pkg::be_merge(data_q, AVS_WRITEDATA_I,
						AVS_BYTEENABLE_I);
				end
				pmx_pkg::OFF_OUT_MODE: begin
					out_mode_d = pmx_pkg::be_merge(out_mode_q,
						AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
				end
				pmx_pkg::OFF_IN_MODE: begin
					in_mode_d = pmx_pkg::be_merge(in_mode_q,
						AVS_WRITEDATA_I, AVS_BYTEENABLE_I)
						& pmx_pkg::IN_MODE_MASK;
				end
				pmx_pkg::OFF_CONFIG: begin
					cfg_d = pmx_pkg::be_merge(cfg_q, AVS_WRITEDATA_I,
						AVS_BYTEENABLE_I) & pmx_pkg::CFG_MASK;
				end
				default: begin
					// unmapped or read-only offsets ignore writes
					data_d = data_q;
				end
			endcase
		end
	end

	// handshake and read data; read data are latched in the wait cycle
	always_comb begin
		ack_d   = req & ~ack_q;
		rdata_d = rdata_q;
		if (AVS_READ_I && !ack_q) begin
			unique case (AVS_ADDRESS_I)
				pmx_pkg::OFF_DATA: begin
					rdata_d = pin_level;
				end
				pmx_pkg::OFF_LATCH: begin
					// read phase of read-modify-write sees stored bits
					rdata_d = data_q;
				end
				pmx_pkg::OFF_OUT_MODE: begin
					rdata_d = out_mode_q;
				end
				pmx_pkg::OFF_IN_MODE: begin
					rdata_d = in_mode_q;
				end
				pmx_pkg::OFF_CONFIG: begin
					rdata_d = cfg_q;
				end
				pmx_pkg::OFF_ALLOC: begin
					rdata_d = alloc;
				end
				default: begin
					rdata_d = 32'h0000_0000;
				end
			endcase
		end
	end

	// register stage for configuration and bus state
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			data_q     <= pmx_pkg::RST_DATA;
			out_mode_q <= pmx_pkg::RST_OUT_MODE;
			in_mode_q  <= pmx_pkg::RST_IN_MODE;
			cfg_q      <= pmx_pkg::RST_CONFIG;
			ack_q      <= 1'b0;
			rdata_q    <= 32'h0000_0000;
		end else begin
			data_q     <= data_d;
			out_mode_q <= out_mode_d;
			in_mode_q  <= in_mode_d;
			cfg_q      <= cfg_d;
			ack_q      <= ack_d;
			rdata_q    <= rdata_d;
		end
	end

	// register stage for pad and peripheral outputs, one cycle behind
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			pad_out_q   <= 32'h0000_0000;
			pad_oe_q    <= 32'h0000_0000;
			pad_pu_q    <= 32'h0000_0000;
			periph_in_q <= 12'h000;
		end else begin
			pad_out_q   <= pad_out_d;
			pad_oe_q    <= pad_oe_d;
			pad_pu_q    <= pad_pu_d;
			periph_in_q <= periph_in_d;
		end
	end

endmodule : pmx_port_ctrl

// ### pmx_pkg.sv
// package with constants, register map and helper functions for the pin mux
package pmx_pkg;

	// pin and function counts
	localparam int NUM_PINS = 32;
	localparam int NUM_FNS  = 12;
	localparam int FN_W     = 4;

	// word-aligned byte offsets on the avalon bus
	localparam logic [7:0] OFF_DATA     = 8'h00;
	localparam logic [7:0] OFF_LATCH    = 8'h04;
	localparam logic [7:0] OFF_OUT_MODE = 8'h08;
	localparam logic [7:0] OFF_IN_MODE  = 8'h0C;
	localparam logic [7:0] OFF_CONFIG   = 8'h10;
	localparam logic [7:0] OFF_ALLOC    = 8'h14;

	// config register field positions
	localparam int CFG_XBAR_EN     = 0;
	localparam int CFG_PU_DIS      = 1;
	localparam int CFG_EXT_MEM_LOW = 2;
	localparam int CFG_EXT_MEM_MUX = 3;
	localparam int CFG_SPI_3WIRE   = 4;
	localparam int CFG_SER0_MODE0  = 5;
	localparam int CFG_SER1_MODE0  = 6;
	localparam int CFG_EN_SER0     = 8;
	localparam int CFG_EN_SPI      = 9;
	localparam int CFG_EN_SMB      = 10;
	localparam int CFG_EN_SER1     = 11;
	localparam int CFG_EN_INT0     = 12;
	localparam int CFG_EN_INT1     = 13;

	// reset values and write masks
	localparam logic [31:0] RST_DATA     = 32'hFFFF_FFFF;
	localparam logic [31:0] RST_OUT_MODE = 32'h0000_0000;
	localparam logic [31:0] RST_IN_MODE  = 32'hFFFF_FF00;
	localparam logic [31:0] RST_CONFIG   = 32'h0000_0000;
	localparam logic [31:0] CFG_MASK     = 32'h0000_3F7F;
	localparam logic [31:0] IN_MODE_MASK = 32'hFFFF_FF00;

	// peripheral functions in priority order, highest first
	localparam int FN_TX0             = 0;
	localparam int FN_SERIAL0_RECEIVE = 1;
	localparam int FN_SCK             = 2;
	localparam int FN_MISO            = 3;
	localparam int FN_MOSI            = 4;
	localparam int FN_SSEL            = 5;
	localparam int FN_SDA             = 6;
	localparam int FN_SCL             = 7;
	localparam int FN_TX1             = 8;
	localparam int FN_SERIAL1_RECEIVE = 9;
	localparam int FN_INT0            = 10;
	localparam int FN_INT1            = 11;

	// functions that are pure inputs to their peripheral: both receive
	// lines and both external interrupts
	localparam logic [11:0] FN_INPUT_MASK = 12'h0E02;

	// reserved pins of group 0 for the memory strobes
	localparam int PIN_ALE = 5;
	localparam int PIN_RD  = 6;
	localparam int PIN_WR  = 7;

	// analog pins of group 2 that the crossbar still may use
	localparam logic [31:0] ANALOG_KEEP = 32'h0003_0000;

	// index of the lowest set bit of a function vector
	function automatic logic [FN_W-1:0] lowest_fn(input logic [11:0] v);
		logic [FN_W-1:0] idx;
		idx = '0;
		for (int i = NUM_FNS - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = FN_W'(i);
			end
		end
		return idx;
	endfunction : lowest_fn

	// byte-enable merge of a bus write into a stored word
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

endpackage : pmx_pkg

// ### pmx_xbar_alloc.sv
// priority crossbar allocator: assigns enabled functions to pins in order
`timescale 1ns/10ps
module pmx_xbar_alloc (
	// function requests and pins to pass over
	input  wire logic [11:0]            fn_en_i,
	input  wire logic [31:0]            skip_i,
	// allocation result per pin
	output logic      [31:0]            alloc_o,
	output logic      [31:0][3:0]       fn_sel_o
);

	logic [11:0] remaining;
	logic [3:0]  idx;

	// walk pins upward, each free pin takes the highest priority waiting
	// function; purely combinational so config changes take effect at once
	always_comb begin
		remaining = fn_en_i;
		idx       = '0;
		alloc_o   = '0;
		fn_sel_o  = '0;
		for (int p = 0; p < pmx_pkg::NUM_PINS; p++) begin
			if (!skip_i[p] && (remaining != 12'h000)) begin
				idx             = pmx_pkg::lowest_fn(remaining);
				alloc_o[p]      = 1'b1;
				fn_sel_o[p]     = idx;
				remaining[idx]  = 1'b0;
			end
		end
	end

endmodule : pmx_xbar_alloc

// ### pmx_port_ctrl_props.sv
// assertion checker for the port pin controller pads and bus
`timescale 1ns/10ps
module pmx_port_ctrl_chk (
	// clock and reset
	input wire logic        CLK_I,
	input wire logic        RST_N_I,
	// avalon-mm slave
	input wire logic [7:0]  AVS_ADDRESS_I,
	input wire logic        AVS_READ_I,
	input wire logic        AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0]  AVS_BYTEENABLE_I,
	input wire logic        AVS_WAITREQUEST_O,
	// pads
	input wire logic [31:0] PAD_OUT_O,
	input wire logic [31:0] PAD_OE_O,
	input wire logic [31:0] PAD_PULLUP_O,
	// memory interface
	input wire logic        EXT_MEM_ACTIVE_I,
	input wire logic        EXT_MEM_READ_I,
	input wire logic [31:0] EXT_MEM_PIN_USE_I,
	input wire logic [31:0] EXT_MEM_PIN_VAL_I,
	input wire logic [31:0] EXT_MEM_DATA_BUS_I
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	logic [31:0] om_q;
	logic [2:0]  cfg_q;
	logic        wr_ok;
	assign wr_ok = AVS_WRITE_I & ~AVS_WAITREQUEST_O;
	// shadow of mode and config bits, taken only at committed writes
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			om_q <= '0;
			cfg_q <= '0;
		end else if (wr_ok) begin
			for (int b = 0; b < 4; b++) begin
				if (AVS_ADDRESS_I == pmx_pkg::OFF_OUT_MODE && AVS_BYTEENABLE_I[b]) begin
					om_q[b*8 +: 8] <= AVS_WRITEDATA_I[b*8 +: 8];
				end
			end
			if (AVS_ADDRESS_I == pmx_pkg::OFF_CONFIG && AVS_BYTEENABLE_I[0]) begin
				cfg_q <= AVS_WRITEDATA_I[2:0];
			end
		end
	end
	property p_xbar_off;
		!cfg_q[0] |=> PAD_OE_O == '0;
	endproperty
	a_xbar_off: assert property (p_xbar_off)
		else $error("pad driven while crossbar off");
	property p_reset_pu;
		$rose(RST_N_I) |=> PAD_PULLUP_O == '1 && PAD_OE_O == '0;
	endproperty
	a_reset_pu: assert property (p_reset_pu)
		else $error("pull-ups not all on after reset");
	property p_pud;
		cfg_q[1] |=> PAD_PULLUP_O == '0;
	endproperty
	a_pud: assert property (p_pud)
		else $error("pull-up on while globally disabled");
	property p_low_pu;
		(PAD_OE_O & ~PAD_OUT_O & PAD_PULLUP_O) == '0;
	endproperty
	a_low_pu: assert property (p_low_pu)
		else $error("pull-up on a pin driven low");
	// pads lag the mode register by one clock
	property p_od;
		(~$past(om_q) & PAD_OE_O & PAD_OUT_O) == '0;
	endproperty
	a_od: assert property (p_od)
		else $error("open-drain pin driven high");
	property p_mem_lvl;
		cfg_q[0] && cfg_q[2] && EXT_MEM_ACTIVE_I && !EXT_MEM_READ_I |=>
			((~PAD_OE_O | PAD_OUT_O) & $past(EXT_MEM_PIN_USE_I))
			== ($past(EXT_MEM_PIN_VAL_I) & $past(EXT_MEM_PIN_USE_I));
	endproperty
	a_mem_lvl: assert property (p_mem_lvl)
		else $error("memory pin level differs from interface");
	property p_mem_rd;
		cfg_q[0] && cfg_q[2] && EXT_MEM_ACTIVE_I && EXT_MEM_READ_I |=>
			(PAD_OE_O & $past(EXT_MEM_DATA_BUS_I)
			& $past(EXT_MEM_PIN_USE_I)) == '0;
	endproperty
	a_mem_rd: assert property (p_mem_rd)
		else $error("data bus driven during memory read");
	property p_wait;
		(AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O;
	endproperty
	a_wait:
	assert property (p_wait) else $error("more than one wait cycle");
endmodule : pmx_port_ctrl_chk
bind pmx_port_ctrl pmx_port_ctrl_chk pmx_port_ctrl_chk_inst (
	.CLK_I(CLK_I), .RST_N_I(RST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
	.AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
	.AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
	.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .PAD_OUT_O(PAD_OUT_O),
	.PAD_OE_O(PAD_OE_O), .PAD_PULLUP_O(PAD_PULLUP_O),
	.EXT_MEM_ACTIVE_I(EXT_MEM_ACTIVE_I), .EXT_MEM_READ_I(EXT_MEM_READ_I),
	.EXT_MEM_PIN_USE_I(EXT_MEM_PIN_USE_I),
	.EXT_MEM_PIN_VAL_I(EXT_MEM_PIN_VAL_I),
	.EXT_MEM_DATA_BUS_I(EXT_MEM_DATA_BUS_I)
);

// ### pmx_board.sv
// board wiring model: resolves pin levels from chip drive and jumpers
`timescale 1ns/10ps
module pmx_board (
	// clock
	input  wire logic        clk_i,
	// chip side
	input  wire logic [31:0] out_i,
	input  wire logic [31:0] oe_i,
	input  wire logic [31:0] pu_i,
	// external drivers on the board
	input  wire logic [31:0] ext_en_i,
	input  wire logic [31:0] ext_val_i,
	// level seen at the pins
	output logic      [31:0] lvl_o
);
	logic [31:0] lvl_q = '0;
	// a pin with nothing on it flips each cycle, so no stale level is read
	always_comb begin
		lvl_o = (ext_en_i & ext_val_i)
			| (~ext_en_i & ((oe_i & out_i) | (~oe_i & (pu_i | ~lvl_q))));
	end
	// last level, source of the floating pattern
	always_ff @(posedge clk_i) begin
		lvl_q <= lvl_o;
	end
endmodule : pmx_board

// ### tb.sv
// self-checking bench for the port pin controller
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("ERROR %s expected %h seen %h", n, e, g); \
	end \
end
module tb;
	logic        CLK_I, RST_N_I, AVS_READ_I, AVS_WRITE_I, AVS_WAITREQUEST_O;
	logic        EXT_MEM_ACTIVE_I, EXT_MEM_READ_I;
	logic [7:0]  AVS_ADDRESS_I;
	logic [3:0]  AVS_BYTEENABLE_I;
	logic [11:0] PERIPH_IN_O, PERIPH_OUT_I, PERIPH_OE_I;
	logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O, PAD_IN_I, PAD_OUT_O;
	logic [31:0] PAD_OE_O, PAD_PULLUP_O;
	logic [31:0] ext_en = 32'h0100_0100;
	logic [31:0] ext_val = 32'h0000_0100;
	logic [31:0] cfg_tab [4] = '{32'h0000_0311, 32'h0000_0301,
		32'h0000_1D05, 32'h0000_1D0D};
	logic [31:0] alc_tab [4] = '{32'h0000_001F, 32'h0000_003F,
		32'h0000_023F, 32'h0000_061F};
	int          mismatches = 0;
	int          comparisons = 0;
	pmx_port_ctrl pmx_port_ctrl_inst (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
		.AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
		.AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
		.AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
		.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .PAD_IN_I(PAD_IN_I),
		.PAD_OUT_O(PAD_OUT_O), .PAD_OE_O(PAD_OE_O), .PAD_PULLUP_O(PAD_PULLUP_O),
		.PERIPH_OUT_I(PERIPH_OUT_I), .PERIPH_OE_I(PERIPH_OE_I),
		.PERIPH_IN_O(PERIPH_IN_O), .EXT_MEM_ACTIVE_I(EXT_MEM_ACTIVE_I),
		.EXT_MEM_READ_I(EXT_MEM_READ_I),
		.EXT_MEM_PIN_USE_I(32'h0000_00E0), .EXT_MEM_PIN_VAL_I(32'h0000_0040),
		.EXT_MEM_DATA_BUS_I(32'h0000_0020));
	pmx_board pmx_board_inst (.clk_i(CLK_I), .out_i(PAD_OUT_O), .oe_i(PAD_OE_O),
		.pu_i(PAD_PULLUP_O), .ext_en_i(ext_en), .ext_val_i(ext_val),
		.lvl_o(PAD_IN_I));
	initial begin
		CLK_I = 1'b0;
		forever #5 CLK_I = ~CLK_I;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge CLK_I);
	endtask : tick
	// one transfer, held until waitrequest is seen low at a rising edge;
	// a slave that never answers is left to the watchdog
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		AVS_ADDRESS_I <= a;
		AVS_WRITEDATA_I <= d;
		AVS_BYTEENABLE_I <= be;
		AVS_WRITE_I <= w;
		AVS_READ_I <= ~w;
		do begin
			@(posedge CLK_I);
		end while (AVS_WAITREQUEST_O !== 1'b0);
		q = AVS_READDATA_O;
		AVS_WRITE_I <= 1'b0;
		AVS_READ_I <= 1'b0;
		@(posedge CLK_I);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be = 4'hF);
		logic [31:0] q;
		bus(1'b1, a, d, be, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, 4'hF, q);
		`CHK("readdata", e, q)
	endtask : rd
	// pads are registered and the inputs registered a cycle after them, so let them settle
	task automatic pads(input logic [31:0] oe, input logic [31:0] out);
		tick(3);
		`CHK("pad_oe", oe, PAD_OE_O)
		`CHK("pad_out", out, PAD_OUT_O)
	endtask : pads
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	initial begin
		RST_N_I = 1'b0;
		{AVS_READ_I, AVS_WRITE_I, EXT_MEM_ACTIVE_I, EXT_MEM_READ_I} = '0;
		{AVS_ADDRESS_I, AVS_WRITEDATA_I, AVS_BYTEENABLE_I} = '0;
		{PERIPH_OUT_I, PERIPH_OE_I} = '1;
		tick(3);
		RST_N_I <= 1'b1;
		tick(1);
		rd(8'h08, 32'h0000_0000);
		rd(8'h0C, 32'hFFFF_FF00);
		// gpio drive styles, first with the crossbar still off
		wr(8'h08, 32'h0000_00F0);
		wr(8'h04, 32'hFFFF_FF5A);
		tick(3);
		`CHK("pad_oe", 32'h0000_0000, PAD_OE_O)
		wr(8'h10, 32'h0000_0001);
		pads(32'h0000_00F5, 32'h0000_0050);
		`CHK("pullup", 32'hFFFF_FF5A, PAD_PULLUP_O)
		rd(8'h00, 32'hFEFF_FF5A);
		rd(8'h04, 32'hFFFF_FF5A);
		// analog pins lose pull-up and digital read
		wr(8'h0C, 32'hFFFE_FE00);
		tick(3);
		`CHK("pullup", 32'hFFFE_FE5A, PAD_PULLUP_O)
		rd(8'h00, 32'hFEFE_FE5A);
		wr(8'h10, 32'h0000_0003);
		tick(3);
		`CHK("pullup", 32'h0000_0000, PAD_PULLUP_O)
		// allocation order, skipped pins and three-wire slave select
		wr(8'h08, 32'hFFFF_FFFF, 4'h1);
		rd(8'h08, 32'h0000_00FF);
		for (int i = 0; i < 4; i++) begin
			wr(8'h10, cfg_tab[i]);
			tick(2);
			rd(8'h14, alc_tab[i]);
		end
		// owned pins ignore data; inputs and smbus lines never drive high;
		// an undriven push-pull pin still shows its value on the out bit
		pads(32'h0000_00F1, 32'h0000_0053);
		`CHK("periph_in", 12'h7C3, PERIPH_IN_O)
		wr(8'h04, 32'hFFFF_FFE0);
		pads(32'h0000_00F1, 32'h0000_00F3);
		// memory interface takes its pins, reads free the data bus
		EXT_MEM_ACTIVE_I <= 1'b1;
		pads(32'h0000_00F1, 32'h0000_0053);
		EXT_MEM_READ_I <= 1'b1;
		tick(3);
		`CHK("pad_oe", 32'h0000_00D1, PAD_OE_O)
		{EXT_MEM_ACTIVE_I, EXT_MEM_READ_I} <= 2'b00;
		// peripherals drive low, let go, and a receive line wants to drive
		PERIPH_OUT_I <= 12'hDBE;
		PERIPH_OE_I <= 12'hEFF;
		pads(32'h0000_00E5, 32'h0000_00F2);
		`CHK("pullup", 32'hFFFE_FEFA, PAD_PULLUP_O)
		// mode-0 serial receive pin is forced to open-drain
		wr(8'h10, 32'h0000_1D2D);
		pads(32'h0000_00E5, 32'h0000_00F0);
		// read-only and unmapped places keep their contents
		wr(8'h14, 32'h0000_0000);
		rd(8'h14, 32'h0000_061F);
		wr(8'h18, 32'hFFFF_FFFF);
		rd(8'h18, 32'h0000_0000);
		// second reset in mid-run
		RST_N_I <= 1'b0;
		tick(2);
		RST_N_I <= 1'b1;
		tick(2);
		`CHK("pad_oe", 32'h0000_0000, PAD_OE_O)
		rd(8'h08, 32'h0000_0000);
		end_sim();
	end
	// watchdog well beyond the roughly 130 cycles the tests need
	initial begin
		tick(5000);
		mismatches++;
		end_sim();
	end
endmodule : tb
